/* File: hw/link_pkg.sv */
package link_pkg;
	// bus style codes on the mode input
	localparam logic ENABLE_DIRECTION_STYLE = 1'b0;
	localparam logic SEPARATE_STROBE_STYLE = 1'b1;
	// link timing, all in link-clock cycles or edges
	localparam logic [3:0] MASTER_LATENCY = 4'h5;
	localparam logic [3:0] SLAVE_LATENCY = 4'h9;
	localparam logic [3:0] WRITE_CYCLES = 4'h5;
	localparam logic [3:0] CTRL_EDGES = 4'h2;
	localparam logic [3:0] WRITE_EDGES = 4'hA;
	localparam logic [3:0] PAYLOAD_BITS = 4'h8;
	localparam logic [3:0] SETUP_CYCLES = 4'h1;
	localparam logic [3:0] PULSE_CYCLES = 4'h3;
	localparam logic [3:0] HOLD_CYCLES = 4'h1;
	localparam logic [3:0] READ_PULSE = 4'h3;
	localparam logic [3:0] FINAL_RISES = 4'h3;
	// display replay schedule, counted in link rises after the payload
	localparam logic [3:0] T_DATA = SLAVE_LATENCY - WRITE_CYCLES;
	localparam logic [3:0] T_FALL = T_DATA + SETUP_CYCLES;
	localparam logic [3:0] T_RISE = T_FALL + PULSE_CYCLES;
	localparam logic [3:0] T_END = T_RISE + HOLD_CYCLES;
	// link period estimate before the first measurement, in clk cycles
	localparam logic [7:0] PERIOD_INIT = 8'h0A;
	typedef enum logic [2:0] {
		M_IDLE = 3'b000, M_WAIT = 3'b001, M_SEND = 3'b011, M_TURN = 3'b010,
		M_RECV = 3'b110, M_FINAL = 3'b111, M_HOLD = 3'b101
	} master_state_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_CTRL = 3'b001, S_PAYLOAD = 3'b011, S_REPLAY = 3'b010,
		S_DISP_RD = 3'b110, S_SEND = 3'b111, S_FINAL = 3'b101
	} slave_state_t;
endpackage

/* File: hw/serial_link_bridge.sv */
`timescale 1ns/1ps
// Summary of operation
// - mode 0 picks enable-plus-direction bus, mode 1 separate strobes, 16 bits
// - each end follows its own mode setting
// - lane low carries bits 7..0, lane high bits 15..8, control on both
// - write: 2 control edges plus 8 payload edges, five link cycles
// - lane low: start, addr/data, payload; lane high: rw, select flag, payload
// - payload goes least significant bit first both ways
// - select flag high for primary select, low for secondary; never both
// - read command is one link cycle, rw flag high
// - after the command lanes turn round; slave drives low by edge 14
// - slave sends high start bit then eight cycles of read data
// - slave launches read data on rising link edges only
// - master finds the start rise and picks its own sampling phase
// - slave drives low one bit then releases; master then drives low
// - no new transaction while a read pair is in progress
// - host reads twice; first returns zero, interrupt flags arrival
// - second read clears the interrupt and returns the data
// - slave releases data after display write, captures read on select rise
// - enable-direction master takes write on select rise or enable fall
// - enable-direction slave holds enable high, strobes with select
// - enable-direction replay: setup 1, select low 3, hold 1, latency 9
// - strobe replay: setup 1, strobe low 3, hold 1, latency 9
module serial_link_bridge (
	input wire logic clk,
	input wire logic rst,
	input wire logic master_sel,
	input wire logic bus_style,
	input wire logic link_clock,
	input wire logic serial_lane_low_in,
	input wire logic serial_lane_high_in,
	output logic serial_lane_low_out,
	output logic serial_lane_high_out,
	output logic serial_lane_low_oe,
	output logic serial_lane_high_oe,
	input wire logic [15:0] par_data_in,
	output logic [15:0] par_data_out,
	output logic par_data_oe,
	input wire logic addr_data_in,
	output logic addr_data_out,
	input wire logic primary_display_select_n_in,
	input wire logic secondary_display_select_n_in,
	output logic primary_display_select_n_out,
	output logic secondary_display_select_n_out,
	input wire logic strobe_a_in,
	input wire logic strobe_b_in,
	output logic strobe_a_out,
	output logic strobe_b_out,
	output logic read_ready_irq
);
	// ****************************************
	// input sampling
	// ****************************************
	logic [25:0] sy1;
	logic [25:0] sy2;
	logic [25:0] sy3;

	function automatic logic sel_active(input logic [25:0] v);
		return !v[3] || !v[2];
	endfunction

	// two flops on every pin and the link clock; third stage for edges and the host write capture
	always_ff @(posedge clk) begin
		sy1 <= {master_sel, link_clock, serial_lane_low_in, serial_lane_high_in, bus_style,
			par_data_in, addr_data_in, primary_display_select_n_in,
			secondary_display_select_n_in, strobe_a_in, strobe_b_in};
		sy2 <= sy1;
		sy3 <= sy2;
	end

	// edge finding and host bus decode
	wire link_rise = sy2[24] & ~sy3[24];
	wire link_edge = sy2[24] ^ sy3[24];
	wire lane_lo = sy2[23];
	wire lane_hi = sy2[22];
	wire style = sy2[21];
	wire sa = sy2[1];
	wire sa_p = sy3[1];
	wire sb = sy2[0];
	wire sb_p = sy3[0];
	wire cs_now = sel_active(sy2);
	wire cs_prev = sel_active(sy3);
	logic taken;
	wire wr_en_fall = cs_now & ~sb & sa_p & ~sa;
	wire wr_cs_rise = cs_prev & ~cs_now & ~sb_p & ~taken;
	wire host_write = style ? (cs_prev & ~sa_p & sa) : (wr_en_fall | wr_cs_rise);
	wire host_read = style ? (cs_now & ~sb & sb_p) : (cs_now & sb & sa & ~sa_p);
	wire read_active = style ? (cs_now & ~sb) : (cs_now & sb & sa);

	// ****************************************
	// role strap and link period
	// ****************************************
	logic strapped;
	logic is_master;
	logic [7:0] pcnt;
	logic [7:0] period;

	// strap caught once, after reset has released
	always_ff @(posedge clk) begin
		if (rst) begin
			strapped <= 1'b0;
			is_master <= 1'b0;
		end else if (!strapped) begin
			strapped <= 1'b1;
			is_master <= sy2[25];
		end
	end

	// clk cycles per link cycle, refreshed on every rise
	always_ff @(posedge clk) begin
		if (rst) begin
			pcnt <= 8'h00;
			period <= link_pkg::PERIOD_INIT;
		end else if (link_rise) begin
			pcnt <= 8'h01;
			period <= pcnt;
		end else begin
			pcnt <= pcnt + 8'h01;
		end
	end

	// ****************************************
	// master end
	// ****************************************
	link_pkg::master_state_t m_state;
	logic wr_pend;
	logic rd_pend;
	logic m_read;
	logic [15:0] wr_word;
	logic wr_ad;
	logic wr_flag;
	logic rd_ad;
	logic rd_flag;
	logic [8:0] tx_lo;
	logic [8:0] tx_hi;
	logic [3:0] m_cnt;
	logic m_l0;
	logic m_l1;
	logic m_oe;
	logic seen_low;
	logic [7:0] timer;
	logic [15:0] rx_word;
	logic m_irq;
	logic [15:0] host_q;
	wire read_busy = rd_pend | m_read;
	wire [8:0] next_lo = wr_pend ? {wr_word[7:0], wr_ad} : {8'h00, rd_ad};
	wire [8:0] next_hi = wr_pend ? {wr_word[15:8], wr_flag} : {8'h00, rd_flag};

	// taking host cycles; enable fall and select rise share one access
	always_ff @(posedge clk) begin
		if (rst) begin
			taken <= 1'b0;
		end else begin
			taken <= cs_now & (taken | wr_en_fall);
		end
	end

	// framing, turnaround and the two-read return
	always_ff @(posedge clk) begin
		if (rst) begin
			m_state <= link_pkg::M_IDLE;
			{wr_pend, rd_pend, m_read, wr_ad, wr_flag, rd_ad, rd_flag} <= 7'h00;
			{m_l0, m_l1, m_oe, seen_low, m_irq} <= 5'h00;
			{wr_word, rx_word, host_q} <= 48'h0;
			{tx_lo, tx_hi} <= 18'h0;
			m_cnt <= 4'h0;
			timer <= 8'h00;
		end else if (is_master) begin
			// writes during a read pair are refused
			if (host_write && !wr_pend && !read_busy) begin
				wr_pend <= 1'b1;
				wr_word <= sy3[20:5];
				wr_ad <= sy3[4];
				wr_flag <= !sy3[3];
			end
			if (host_read) begin
				host_q <= (m_state == link_pkg::M_HOLD) ? rx_word : 16'h0000;
				if (m_state == link_pkg::M_HOLD) begin
					m_irq <= 1'b0;
					m_read <= 1'b0;
					m_state <= link_pkg::M_IDLE;
				end else if (!read_busy) begin
					rd_pend <= 1'b1;
					rd_ad <= sy2[4];
					rd_flag <= !sy2[3];
				end
			end
			unique case (m_state)
				link_pkg::M_IDLE: begin
					{m_oe, m_l0, m_l1} <= 3'b100;
					m_cnt <= 4'h0;
					if (wr_pend || rd_pend) m_state <= link_pkg::M_WAIT;
				end
				link_pkg::M_WAIT: if (link_rise) begin
					m_cnt <= m_cnt + 4'h1;
					if (m_cnt + 4'h1 == link_pkg::MASTER_LATENCY) begin
						m_state <= link_pkg::M_SEND;
						m_read <= !wr_pend;
						m_l0 <= 1'b1;
						m_l1 <= !wr_pend;
						tx_lo <= next_lo;
						tx_hi <= next_hi;
						m_cnt <= 4'h1;
						if (wr_pend) wr_pend <= 1'b0;
						else rd_pend <= 1'b0;
					end
				end
				link_pkg::M_SEND: if (link_edge) begin
					if (m_cnt == (m_read ? link_pkg::CTRL_EDGES : link_pkg::WRITE_EDGES)) begin
						{m_l0, m_l1} <= 2'b00;
						if (m_read) begin
							m_oe <= 1'b0;
							seen_low <= 1'b0;
							m_state <= link_pkg::M_TURN;
						end else begin
							m_state <= link_pkg::M_IDLE;
						end
					end else begin
						m_l0 <= tx_lo[0];
						m_l1 <= tx_hi[0];
						tx_lo <= {1'b0, tx_lo[8:1]};
						tx_hi <= {1'b0, tx_hi[8:1]};
						m_cnt <= m_cnt + 4'h1;
					end
				end
				link_pkg::M_TURN: begin
					if (!lane_lo) seen_low <= 1'b1;
					// sample point placed mid-bit from the start rise
					if (seen_low && lane_lo) begin
						timer <= 8'(period + (period >> 1));
						m_cnt <= 4'h0;
						m_state <= link_pkg::M_RECV;
					end
				end
				link_pkg::M_RECV: begin
					if (timer == 8'h00) begin
						rx_word <= {lane_hi, rx_word[15:9], lane_lo, rx_word[7:1]};
						timer <= 8'(period - 8'h01);
						m_cnt <= m_cnt + 4'h1;
						if (m_cnt + 4'h1 == link_pkg::PAYLOAD_BITS) begin
							m_cnt <= 4'h0;
							m_state <= link_pkg::M_FINAL;
						end
					end else begin
						timer <= timer - 8'h01;
					end
				end
				link_pkg::M_FINAL: if (link_rise) begin
					m_cnt <= m_cnt + 4'h1;
					// slave low bit and release pass before we drive again
					if (m_cnt + 4'h1 == link_pkg::FINAL_RISES) begin
						m_oe <= 1'b1;
						m_irq <= 1'b1;
						m_state <= link_pkg::M_HOLD;
					end
				end
				link_pkg::M_HOLD: begin
				end
				default: m_state <= link_pkg::M_IDLE;
			endcase
		end
	end

	// ****************************************
	// slave end
	// ****************************************
	link_pkg::slave_state_t s_state;
	logic s_rw;
	logic s_ad;
	logic s_flag;
	logic [15:0] s_word;
	logic [3:0] s_cnt;
	logic s_l0;
	logic s_l1;
	logic s_oe;
	logic s_doe;
	logic s_cs1n;
	logic s_cs2n;
	logic s_sa;
	logic s_sb;

	// receive, replay to the display, return read data
	always_ff @(posedge clk) begin
		if (rst) begin
			s_state <= link_pkg::S_IDLE;
			{s_rw, s_ad, s_flag, s_l0, s_l1, s_oe, s_doe} <= 7'h20;
			{s_cs1n, s_cs2n, s_sa, s_sb} <= 4'hF;
			s_word <= 16'h0000;
			s_cnt <= 4'h0;
		end else if (strapped && !is_master) begin
			unique case (s_state)
				link_pkg::S_IDLE: begin
					s_cnt <= 4'h0;
					if (link_edge && lane_lo) begin
						s_rw <= lane_hi;
						s_state <= link_pkg::S_CTRL;
					end
				end
				link_pkg::S_CTRL: if (link_edge) begin
					s_ad <= lane_lo;
					s_flag <= lane_hi;
					if (s_rw) begin
						// drive low right away, well inside edge 14
						{s_oe, s_l0, s_l1} <= 3'b100;
						s_state <= link_pkg::S_DISP_RD;
					end else begin
						s_state <= link_pkg::S_PAYLOAD;
					end
				end
				link_pkg::S_PAYLOAD: if (link_edge) begin
					s_word <= {lane_hi, s_word[15:9], lane_lo, s_word[7:1]};
					s_cnt <= s_cnt + 4'h1;
					if (s_cnt + 4'h1 == link_pkg::PAYLOAD_BITS) begin
						s_cnt <= 4'h0;
						s_state <= link_pkg::S_REPLAY;
					end
				end
				link_pkg::S_REPLAY: if (link_rise) begin
					s_cnt <= s_cnt + 4'h1;
					if (s_cnt == link_pkg::T_DATA) begin
						s_doe <= 1'b1;
						s_sb <= style;
						if (style) {s_cs1n, s_cs2n} <= {!s_flag, s_flag};
					end
					if (s_cnt == link_pkg::T_FALL) begin
						if (style) s_sa <= 1'b0;
						else {s_cs1n, s_cs2n} <= {!s_flag, s_flag};
					end
					if (s_cnt == link_pkg::T_RISE) begin
						if (style) s_sa <= 1'b1;
						else {s_cs1n, s_cs2n} <= 2'b11;
					end
					if (s_cnt == link_pkg::T_END) begin
						s_doe <= 1'b0;
						{s_cs1n, s_cs2n, s_sb} <= 3'b111;
						s_state <= link_pkg::S_IDLE;
					end
				end
				link_pkg::S_DISP_RD: if (link_rise) begin
					s_cnt <= s_cnt + 4'h1;
					if (s_cnt == 4'h0) begin
						{s_cs1n, s_cs2n} <= {!s_flag, s_flag};
						s_sb <= ~style;
					end
					// capture as the select rises; display data is stable then
					if (s_cnt == link_pkg::READ_PULSE) begin
						{s_cs1n, s_cs2n, s_sb} <= 3'b111;
						s_word <= sy2[20:5];
						s_cnt <= 4'h0;
						s_state <= link_pkg::S_SEND;
					end
				end
				link_pkg::S_SEND: if (link_rise) begin
					s_cnt <= s_cnt + 4'h1;
					if (s_cnt == 4'h0) begin
						{s_l0, s_l1} <= 2'b11;
					end else if (s_cnt <= link_pkg::PAYLOAD_BITS) begin
						s_l0 <= s_word[0];
						s_l1 <= s_word[8];
						s_word <= {1'b0, s_word[15:9], 1'b0, s_word[7:1]};
					end else begin
						{s_l0, s_l1} <= 2'b00;
						s_state <= link_pkg::S_FINAL;
					end
				end
				link_pkg::S_FINAL: if (link_rise) begin
					s_oe <= 1'b0;
					s_state <= link_pkg::S_IDLE;
				end
				default: s_state <= link_pkg::S_IDLE;
			endcase
		end
	end

	// ****************************************
	// pin registers
	// ****************************************
	// every output leaves from a flop, role picks the source of the lanes and parallel data
	always_ff @(posedge clk) begin
		if (rst) begin
			{serial_lane_low_out, serial_lane_high_out} <= 2'b00;
			{serial_lane_low_oe, serial_lane_high_oe} <= 2'b00;
			par_data_out <= 16'h0000;
			par_data_oe <= 1'b0;
			addr_data_out <= 1'b1;
			{primary_display_select_n_out, secondary_display_select_n_out} <= 2'b11;
			{strobe_a_out, strobe_b_out} <= 2'b11;
			read_ready_irq <= 1'b0;
		end else begin
			serial_lane_low_out <= is_master ? m_l0 : s_l0;
			serial_lane_high_out <= is_master ? m_l1 : s_l1;
			serial_lane_low_oe <= is_master ? m_oe : s_oe;
			serial_lane_high_oe <= is_master ? m_oe : s_oe;
			par_data_out <= is_master ? host_q : s_word;
			par_data_oe <= is_master ? read_active : s_doe;
			addr_data_out <= s_ad;
			primary_display_select_n_out <= s_cs1n;
			secondary_display_select_n_out <= s_cs2n;
			strobe_a_out <= s_sa | (style == link_pkg::ENABLE_DIRECTION_STYLE);
			strobe_b_out <= s_sb;
			read_ready_irq <= m_irq;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	start_bit_a: assert property ($rose(m_state == link_pkg::M_SEND) |-> m_l0 && m_oe)
		else $error("frame did not open with a high start bit");
	rw_flag_a: assert property ($rose(m_state == link_pkg::M_SEND) |-> m_l1 == m_read)
		else $error("rw flag does not match the transaction kind");
	frame_len_a: assert property ($fell(m_state == link_pkg::M_SEND)
		|-> $past(m_cnt) == ($past(m_read) ? 4'h2 : 4'hA))
		else $error("frame length wrong");
	turn_release_a: assert property (m_state == link_pkg::M_TURN |-> !m_oe)
		else $error("master drives lanes during turnaround");
	slave_low_a: assert property (s_state == link_pkg::S_DISP_RD |-> s_oe && !s_l0 && !s_l1)
		else $error("slave not holding lanes low");
	recv_bits_a: assert property ($rose(m_state == link_pkg::M_FINAL) |-> $past(m_cnt) == 4'h7)
		else $error("read payload not eight bits");
	first_zero_a: assert property (is_master && host_read && m_state != link_pkg::M_HOLD
		|=> host_q == 16'h0000)
		else $error("first read not zero");
	irq_clear_a: assert property (is_master && host_read && m_state == link_pkg::M_HOLD
		|=> !m_irq && host_q == $past(rx_word) ##1 !read_ready_irq)
		else $error("second read did not clear interrupt");
	no_overlap_a: assert property (m_read && m_state != link_pkg::M_SEND
		&& m_state != link_pkg::M_WAIT |=> m_state != link_pkg::M_SEND)
		else $error("transaction started inside a read");
	enable_high_a: assert property (!is_master && !style |=> strobe_a_out)
		else $error("enable output dropped");
	strobe_data_a: assert property ($changed(s_sa) && s_state == link_pkg::S_REPLAY |-> s_doe)
		else $error("write strobe moved while data off");
	select_flag_a: assert property (!s_cs1n || !s_cs2n |-> s_cs1n != s_cs2n && s_cs1n == !s_flag)
		else $error("display select does not follow flag");

	write_sent_c: cover property ($fell(m_state == link_pkg::M_SEND) && !m_read);
	read_pair_c: cover property (m_state == link_pkg::M_HOLD && host_read);
	replay_done_c: cover property (s_state == link_pkg::S_REPLAY ##1 s_state == link_pkg::S_IDLE);
endmodule

/* File: dv/display_model.sv */
`timescale 1ns/1ps
// ********
// display stand-in at the slave's parallel side
// ********
module display_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic style,
	input wire logic [15:0] data_out,
	input wire logic data_oe,
	input wire logic ad_out,
	input wire logic prim_n,
	input wire logic sec_n,
	input wire logic stb_a,
	input wire logic stb_b,
	input wire logic [15:0] rd_value,
	output logic [15:0] data_in,
	output logic wr_valid,
	output logic [15:0] wr_data,
	output logic wr_ad,
	output logic wr_prim,
	output int wr_width,
	output int bad
);
	logic wr_n;
	logic rd_n;
	logic prev_wr_n;
	logic prev_prim_n;
	int low_cnt;
	int hold;
	// write strobe is the select in style 0, the write line in style 1
	assign wr_n = style ? stb_a : ((prim_n & sec_n) | stb_b);
	assign rd_n = style ? stb_b : ((prim_n & sec_n) | ~stb_b);
	// inverse outside the read window and its four-clk hold, so a late capture cannot pass by luck
	assign data_in = (!rd_n || hold > 0) ? rd_value : ~rd_value;
	// strobe width, setup and capture of each replayed write
	always @(posedge clk) begin
		prev_wr_n <= wr_n;
		prev_prim_n <= prim_n;
		wr_valid <= 1'h0;
		hold <= !rd_n ? 4 : (hold > 0 ? hold - 1 : 0);
		low_cnt <= wr_n ? 0 : low_cnt + 1;
		if (!rst && !style && stb_a !== 1'h1) bad <= bad + 1;
		if (!rst && prev_wr_n && !wr_n && !data_oe) bad <= bad + 1;
		if (!rst && !prev_wr_n && wr_n) begin
			wr_valid <= 1'h1;
			{wr_ad, wr_prim, wr_data, wr_width} <= {ad_out, !prev_prim_n, data_out, low_cnt};
		end
	end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic clk, rst, link_clock, ms, ss, m_role, s_role, m_doe, lo_prev;
	logic [15:0] h_data, rd_value, m_dout, s_dout, s_din, wr_data, got;
	logic h_ad, h_prim_n, h_sec_n, h_a, h_b, lane_lo, lane_hi;
	logic m_lo, m_hi, m_lo_oe, m_hi_oe, s_lo, s_hi, s_lo_oe, s_hi_oe;
	logic s_doe, s_ad, s_p_n, s_s_n, s_a, s_b, m_irq, wr_valid, wr_ad, wr_prim;
	logic [9:0] flo, fhi;
	logic [17:0] disp_q[$];
	logic [17:0] frame_q[$];
	logic [17:0] e_f, e_d;
	logic [31:0] r;
	int wr_width, bad, n_errors, checked, cycles, fcnt, seed, i;
	// ********
	// clocks and wire
	// ********
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	// link clock free running, phase unrelated to clk
	initial begin
		link_clock = 1'h0;
		#1.3;
		forever #24 link_clock = ~link_clock;
	end
	// bench pull-down while neither end drives
	assign lane_lo = m_lo_oe ? m_lo : (s_lo_oe ? s_lo : 1'h0);
	assign lane_hi = m_hi_oe ? m_hi : (s_hi_oe ? s_hi : 1'h0);
	serial_link_bridge serial_link_bridge_i (.clk(clk), .rst(rst), .master_sel(m_role),
		.bus_style(ms), .link_clock(link_clock), .serial_lane_low_in(lane_lo),
		.serial_lane_high_in(lane_hi), .serial_lane_low_out(m_lo), .serial_lane_high_out(m_hi),
		.serial_lane_low_oe(m_lo_oe), .serial_lane_high_oe(m_hi_oe), .par_data_in(h_data),
		.par_data_out(m_dout), .par_data_oe(m_doe), .addr_data_in(h_ad), .addr_data_out(),
		.primary_display_select_n_in(h_prim_n), .secondary_display_select_n_in(h_sec_n),
		.primary_display_select_n_out(), .secondary_display_select_n_out(),
		.strobe_a_in(h_a), .strobe_b_in(h_b), .strobe_a_out(), .strobe_b_out(),
		.read_ready_irq(m_irq));
	serial_link_bridge slave_serial_link_bridge_i (.clk(clk), .rst(rst), .master_sel(s_role),
		.bus_style(ss), .link_clock(link_clock), .serial_lane_low_in(lane_lo),
		.serial_lane_high_in(lane_hi), .serial_lane_low_out(s_lo), .serial_lane_high_out(s_hi),
		.serial_lane_low_oe(s_lo_oe), .serial_lane_high_oe(s_hi_oe), .par_data_in(s_din),
		.par_data_out(s_dout), .par_data_oe(s_doe), .addr_data_in(1'h1), .addr_data_out(s_ad),
		.primary_display_select_n_in(1'h1), .secondary_display_select_n_in(1'h1),
		.primary_display_select_n_out(s_p_n), .secondary_display_select_n_out(s_s_n),
		.strobe_a_in(1'h1), .strobe_b_in(1'h1), .strobe_a_out(s_a), .strobe_b_out(s_b),
		.read_ready_irq());
	display_model display_model_i (.clk(clk), .rst(rst), .style(ss), .data_out(s_dout),
		.data_oe(s_doe), .ad_out(s_ad), .prim_n(s_p_n), .sec_n(s_s_n), .stb_a(s_a),
		.stb_b(s_b), .rd_value(rd_value), .data_in(s_din), .wr_valid(wr_valid),
		.wr_data(wr_data), .wr_ad(wr_ad), .wr_prim(wr_prim), .wr_width(wr_width), .bad(bad));
	// ********
	// checking
	// ********
	task automatic check(string what, logic [19:0] seen, logic [19:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// hang guard, well above the four style passes
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			end_sim();
		end
	end
	// write frames on the wire, sampled at each link edge once bits have settled
	always @(link_clock) begin
		// a write start follows idle low lanes; a read command's second bit never does
		if (fcnt > 0 || (lo_prev === 1'h0 && m_lo_oe === 1'h1 && lane_lo === 1'h1
			&& lane_hi === 1'h0)) begin
			flo = {lane_lo, flo[9:1]};
			fhi = {lane_hi, fhi[9:1]};
			fcnt++;
		end
		if (fcnt == 10) begin
			fcnt = 0;
			if (frame_q.size() == 0) begin
				check("unexpected frame", 1'h1, 1'h0);
			end else begin
				e_f = frame_q.pop_front();
				check("lanes", {fhi, flo}, {e_f[15:8], e_f[16], 1'h0, e_f[7:0], e_f[17], 1'h1});
			end
		end
		lo_prev = lane_lo;
	end
	// display-side replays against the notes left by the host driver
	always @(posedge clk) begin
		if (wr_valid === 1'h1) begin
			if (disp_q.size() == 0) begin
				check("unexpected display write", 1'h1, 1'h0);
			end else begin
				e_d = disp_q.pop_front();
				check("display write", {wr_ad, wr_prim, wr_data}, e_d);
				check("strobe width", wr_width >= 25 && wr_width <= 32, 1'h1);
			end
		end
	end
	// ********
	// host driver
	// ********
	task automatic do_reset(logic m_style, logic s_style);
		@(posedge clk);
		{rst, ms, ss, h_prim_n, h_sec_n, h_a, h_b} <= {1'h1, m_style, s_style, 2'h3, m_style, 1'h1};
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		#1;
		check("reset state", {m_irq, s_ad, s_p_n, s_s_n, m_lo_oe}, 5'h0E);
		repeat (60) @(posedge clk);
	endtask
	// style 0 may end with the select rise ahead of the enable fall
	task automatic host_write(logic ad, logic prim, logic [15:0] d, logic push, logic sel_first);
		@(posedge clk);
		{h_data, h_ad, h_prim_n, h_sec_n, h_b, h_a} <= {d, ad, !prim, prim, ms, 1'h1};
		repeat (3) @(posedge clk);
		if (ms) h_a <= 1'h0;
		repeat (4) @(posedge clk);
		if (ms || !sel_first) h_a <= ms;
		else {h_prim_n, h_sec_n} <= 2'h3;
		repeat (4) @(posedge clk);
		{h_prim_n, h_sec_n, h_a, h_b} <= {2'h3, ms, 1'h1};
		if (push) begin
			disp_q.push_back({ad, prim, d});
			frame_q.push_back({ad, prim, d});
		end
		repeat (300) @(posedge clk);
		if (push) check("data released", s_doe, 1'h0);
	endtask
	// select settles one clk before the read strobe or enable moves
	task automatic host_read(logic prim, output logic [15:0] val);
		@(posedge clk);
		{h_prim_n, h_sec_n} <= {!prim, prim};
		@(posedge clk);
		{h_a, h_b} <= {1'h1, !ms};
		repeat (12) @(posedge clk);
		check("read drive", m_doe, 1'h1);
		val = m_dout;
		{h_prim_n, h_sec_n, h_a, h_b} <= {2'h3, ms, 1'h1};
		repeat (80) @(posedge clk);
	endtask
	// ********
	// main sequence: every pairing of the two ends' styles
	// ********
	initial begin
		{rst, ms, ss, h_data, h_ad, h_prim_n, h_sec_n, h_a, h_b} = {3'h5, 16'h0000, 5'h1F};
		{rd_value, seed, fcnt, n_errors, checked, cycles} = {16'h0000, 32'd71, 128'd0};
		{m_role, s_role} = 2'h2;
		for (int c = 0; c < 4; c++) begin
			do_reset(c[0], c[1]);
			host_write(1'h1, 1'h1, 16'h1234, 1'h1, 1'h0);
			repeat (3) begin
				r = $random(seed);
				host_write(r[16], r[17], r[15:0], 1'h1, r[18]);
			end
			r = $random(seed);
			rd_value <= r[15:0];
			host_read(r[19], got);
			check("first read", got, 16'h0000);
			host_write(r[16], r[17], ~r[15:0], 1'h0, 1'h0);
			for (i = 0; i < 3000 && m_irq !== 1'h1; i++) @(posedge clk);
			check("irq raised", m_irq, 1'h1);
			host_read(r[19], got);
			check("second read", got, r[15:0]);
			check("irq cleared", m_irq, 1'h0);
			$display("test styles %0d done", c);
		end
		check("display model faults", bad, 20'h00000);
		check("notes left over", disp_q.size() + frame_q.size(), 20'h00000);
		end_sim();
	end
endmodule
